// *** rtl/video_port_a_sync.sv ***
// port a sync configuration, pin steering and strobe derivation
// assumes apb master on clk; pins, line clocks and data are async
// to clk and are synchronised here; scaler gates are on clk
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
// Contract
// - line clock bit: input, or copy port b
// - sync config 00: both pins input, undriven
// - config 01: drive horizontal-phase scaler gates
// - config 10: field memory reset, vsync in
// - config 11: drive binary-ratio scaler gates
// - vertical polarity bit inverts driven vsync
// - horizontal polarity bit inverts driven hsync
// - derivation field picks strobe source, pins or stream codes
// - code 000: rising edges, field at vsync rise
// - code 001: vsync falling, field at fall
// - codes 010/011: field forced toggle at fall
// - codes 100/101: field toggles freely
// - code 110: both frame sync edges, field follows
// - code 111: strobes from stream timing codes
// - field edge select raises interrupt condition
module video_port_a_sync
  import video_port_a_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [video_port_a_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_clock_port_a_in,
  output logic line_clock_port_a_out,
  output logic line_clock_port_a_oe,
  input wire logic line_clock_port_b_in,
  input wire logic hsync_pin_a_in,
  output logic hsync_pin_a_out,
  output logic hsync_pin_a_oe,
  input wire logic vsync_pin_a_in,
  output logic vsync_pin_a_out,
  output logic vsync_pin_a_oe,
  input wire logic [7:0] video_port_a,
  input wire logic hps_horizontal_gate,
  input wire logic hps_vertical_gate,
  input wire logic brs_horizontal_gate,
  input wire logic brs_vertical_gate,
  input wire logic field_memory_reset,
  input wire logic hscaler_source_select_msb,
  output logic brs_vsync,
  output logic internal_hstrobe_a,
  output logic internal_vstrobe_a,
  output logic internal_field_flag_a,
  output logic irq
);
  import video_port_a_pkg::*;

  // ==========================================================
  // declarations
  // ==========================================================
  logic [31:0] setting; // only the kept bits ever become set
  logic [irq_w-1:0] irq_status; // sticky events
  logic [irq_w-1:0] irq_mask; // one enables an event
  logic [11:0] pins_s; // synchronised pin levels
  logic lca_s; // line clock a, synchronised
  logic lcb_s; // line clock b, synchronised
  logic hs_s; // hsync pin, synchronised
  logic vs_s; // vsync pin, synchronised
  logic [7:0] data_s; // video data, synchronised
  logic lc_prev; // selected line clock, last cycle
  logic lc_rise; // byte sample pulse for the decoder
  logic dec_h; // decoded horizontal blanking level
  logic dec_v; // decoded vertical blanking level
  logic dec_f; // decoded field level
  logic h_src; // level the strobes derive from
  logic v_src;
  logic h_prev; // source levels, last cycle
  logic v_prev;
  logic h_rise;
  logic v_rise;
  logic v_fall;
  logic field_prev; // field flag, last cycle
  logic field_event; // field edge that is an irq condition
  logic next_hs_out; // pin drive values before the flop
  logic next_hs_oe;
  logic next_vs_out;
  logic next_vs_oe;
  logic next_field;
  logic next_vstrobe;
  logic next_hstrobe;
  logic setup; // apb access phase, first cycle
  logic take; // apb edge at which the transfer completes
  logic mapped; // paddr hits one of the words
  logic [irq_w-1:0] w1c; // status bits software clears
  logic [31:0] read_word;
  sync_cfg_t sync_cfg;
  deriv_t deriv;
  edge_sel_t edge_sel;

  // ==========================================================
  // field views of the setting word
  // ==========================================================
  assign sync_cfg = sync_cfg_t'(setting[sync_cfg_hi:sync_cfg_lo]);
  assign deriv = deriv_t'(setting[deriv_hi:deriv_lo]);
  assign edge_sel = edge_sel_t'(setting[edge_sel_hi:edge_sel_lo]);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  // every async level crosses through two flops before use
  pin_sync #(
    .width(12)
  ) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({line_clock_port_a_in, line_clock_port_b_in,
        hsync_pin_a_in, vsync_pin_a_in, video_port_a}),
    .q(pins_s)
  );
  assign lca_s = pins_s[11];
  assign lcb_s = pins_s[10];
  assign hs_s = pins_s[9];
  assign vs_s = pins_s[8];
  assign data_s = pins_s[7:0];

  // ==========================================================
  // apb slave: one wait state, answer registered
  // ==========================================================
  assign setup = psel && penable && !pready;
  assign take = psel && penable && pready;
  assign mapped = (paddr == setting_addr) ||
                  (paddr == irq_status_addr) ||
                  (paddr == irq_mask_addr) ||
                  (paddr == state_addr);

  // pready rises one cycle into the access phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // read mux; unimplemented and reserved bits read zero
  always_comb begin
    read_word = 32'h0;
    case (paddr)
      setting_addr: read_word = setting & setting_keep;
      irq_status_addr: read_word[irq_w-1:0] = irq_status;
      irq_mask_addr: read_word[irq_w-1:0] = irq_mask;
      state_addr: read_word[state_w-1:0] =
        {lc_prev, v_src, h_src, internal_vstrobe_a,
         internal_hstrobe_a, internal_field_flag_a};
      default: read_word = 32'h0;
    endcase
  end

  // answer captured with pready, held until the next answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : read_word;
      pslverr <= !mapped;
    end
  end

  // ==========================================================
  // setting register
  // ==========================================================
  // writes apply at once; ordering is
  // left to software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setting <= setting_reset;
    end else if (take && pwrite && paddr == setting_addr) begin
      setting <= pwdata & setting_keep;
    end
  end

  // mask register, same layout as status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= irq_reset;
    end else if (take && pwrite && paddr == irq_mask_addr) begin
      irq_mask <= pwdata[irq_w-1:0];
    end
  end

  // ==========================================================
  // line clock pin
  // ==========================================================
  // copy lags port b by three clk cycles;
  // tolerable against a slow pixel clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_clock_port_a_out <= 1'b0;
      line_clock_port_a_oe <= 1'b0;
    end else begin
      line_clock_port_a_oe <= setting[line_clock_dir_bit];
      line_clock_port_a_out <= setting[line_clock_dir_bit] ?
                               lcb_s : 1'b0;
    end
  end

  // ==========================================================
  // sync pin drive selection
  // ==========================================================
  always_comb begin
    next_hs_out = 1'b0;
    next_hs_oe = 1'b0;
    next_vs_out = 1'b0;
    next_vs_oe = 1'b0;
    case (sync_cfg)
      sync_pins_in: begin
        next_hs_oe = 1'b0;
        next_vs_oe = 1'b0;
      end
      sync_hps_out: begin
        next_hs_oe = 1'b1;
        next_vs_oe = 1'b1;
        next_hs_out = hps_horizontal_gate;
        next_vs_out = hps_vertical_gate;
      end
      sync_field_mem: begin
        // vsync stays an input and feeds the ratio scaler
        next_hs_oe = 1'b1;
        next_hs_out = field_memory_reset;
      end
      sync_brs_out: begin
        next_hs_oe = 1'b1;
        next_vs_oe = 1'b1;
        next_hs_out = brs_horizontal_gate;
        next_vs_out = brs_vertical_gate;
      end
      default: begin
        next_hs_oe = 1'b0;
        next_vs_oe = 1'b0;
      end
    endcase
    // polarity only matters while the pin is driven
    if (next_hs_oe && setting[hpol_bit]) begin
      next_hs_out = !next_hs_out;
    end
    if (next_vs_oe && setting[vpol_bit]) begin
      next_vs_out = !next_vs_out;
    end
  end

  // pin flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsync_pin_a_out <= 1'b0;
      hsync_pin_a_oe <= 1'b0;
      vsync_pin_a_out <= 1'b0;
      vsync_pin_a_oe <= 1'b0;
    end else begin
      hsync_pin_a_out <= next_hs_out;
      hsync_pin_a_oe <= next_hs_oe;
      vsync_pin_a_out <= next_vs_out;
      vsync_pin_a_oe <= next_vs_oe;
    end
  end

  // vsync pin into the ratio scaler in field memory mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brs_vsync <= 1'b0;
    end else begin
      brs_vsync <= (sync_cfg == sync_field_mem) ? vs_s : 1'b0;
    end
  end

  // ==========================================================
  // stream timing code recovery
  // ==========================================================
  // bytes are taken on the rising edge of whichever line clock
  // the port is using: its own pin, or the copy of port b
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lc_prev <= 1'b0;
    end else begin
      lc_prev <= setting[line_clock_dir_bit] ? lcb_s : lca_s;
    end
  end
  assign lc_rise = !lc_prev &&
                   (setting[line_clock_dir_bit] ? lcb_s : lca_s);

  timing_code_decoder u_decoder (
    .clk(clk),
    .rst_b(rst_b),
    .sample(lc_rise),
    .data(data_s),
    .h_level(dec_h),
    .v_level(dec_v),
    .f_level(dec_f)
  );

  // ==========================================================
  // strobe source and edges
  // ==========================================================
  // driven pins use the flop level,
  // input pins the synchronised level
  always_comb begin
    if (deriv == der_stream_codes) begin
      h_src = dec_h;
      v_src = dec_v;
    end else begin
      h_src = hsync_pin_a_oe ? hsync_pin_a_out : hs_s;
      v_src = vsync_pin_a_oe ? vsync_pin_a_out : vs_s;
    end
  end

  // previous source levels for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      h_prev <= 1'b0;
      v_prev <= 1'b0;
    end else begin
      h_prev <= h_src;
      v_prev <= v_src;
    end
  end
  assign h_rise = h_src && !h_prev;
  assign v_rise = v_src && !v_prev;
  assign v_fall = !v_src && v_prev;

  // ==========================================================
  // strobe and field derivation per mode
  // ==========================================================
  always_comb begin
    next_hstrobe = h_rise;
    next_vstrobe = 1'b0;
    next_field = internal_field_flag_a;
    case (deriv)
      der_rise_direct: begin
        next_vstrobe = v_rise;
        if (v_rise) next_field = h_src;
      end
      der_fall_direct: begin
        next_vstrobe = v_fall;
        if (v_fall) next_field = h_src;
      end
      der_rise_forced, der_fall_forced: begin
        next_vstrobe = (deriv == der_rise_forced) ?
                       v_rise : v_fall;
        // a repeated hsync sample is overridden: always alternates
        if (v_fall) next_field = (h_src != internal_field_flag_a) ?
                                 h_src : !internal_field_flag_a;
      end
      der_rise_free: begin
        next_vstrobe = v_rise;
        if (v_rise) next_field = !internal_field_flag_a;
      end
      der_fall_free: begin
        next_vstrobe = v_fall;
        if (v_fall) next_field = !internal_field_flag_a;
      end
      der_frame_sync: begin
        next_vstrobe = v_rise || v_fall;
        next_field = v_src;
      end
      der_stream_codes: begin
        // unusable while the scaler takes the other source
        next_hstrobe = h_rise && !hscaler_source_select_msb;
        next_vstrobe = v_rise && !hscaler_source_select_msb;
        if (!hscaler_source_select_msb) next_field = dec_f;
      end
      default: begin
        next_vstrobe = 1'b0;
      end
    endcase
  end

  // strobe outputs are one-cycle pulses, field is a level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_hstrobe_a <= 1'b0;
      internal_vstrobe_a <= 1'b0;
      internal_field_flag_a <= 1'b0;
      field_prev <= 1'b0;
    end else begin
      internal_hstrobe_a <= next_hstrobe;
      internal_vstrobe_a <= next_vstrobe;
      internal_field_flag_a <= next_field;
      field_prev <= internal_field_flag_a;
    end
  end

  // ==========================================================
  // field identity edge condition and interrupt
  // ==========================================================
  // odd field is flag one, so a rising edge starts an odd field
  always_comb begin
    case (edge_sel)
      edge_none: field_event = 1'b0;
      edge_rise: field_event = internal_field_flag_a &&
                               !field_prev;
      edge_fall: field_event = !internal_field_flag_a &&
                               field_prev;
      edge_both: field_event = internal_field_flag_a !=
                               field_prev;
      default: field_event = 1'b0;
    endcase
  end

  assign w1c = (take && pwrite && paddr == irq_status_addr) ?
               pwdata[irq_w-1:0] : {irq_w{1'b0}};

  // sticky status; a new event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= irq_reset;
    end else begin
      irq_status[irq_field_bit] <= field_event ||
        (irq_status[irq_field_bit] && !w1c[irq_field_bit]);
    end
  end

  // level interrupt, one cycle behind status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule // video_port_a_sync

// *** rtl/video_port_a_pkg.sv ***
// constants, field layout and mode encodings of the port a sync block
// assumes a 32-bit apb register bus with byte addresses in paddr
package video_port_a_pkg;
  // ==========================================================
  // register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] setting_addr = 8'h50; // port setting word
  localparam logic [7:0] irq_status_addr = 8'h54; // sticky events
  localparam logic [7:0] irq_mask_addr = 8'h58; // interrupt enables
  localparam logic [7:0] state_addr = 8'h5c; // live sync state
  localparam int addr_w = 8; // paddr width

  // ==========================================================
  // setting word field positions
  // ==========================================================
  localparam int line_clock_dir_bit = 31;
  localparam int sync_cfg_hi = 30;
  localparam int sync_cfg_lo = 29;
  localparam int vpol_bit = 28;
  localparam int hpol_bit = 27;
  localparam int deriv_hi = 26;
  localparam int deriv_lo = 24;
  localparam int edge_sel_hi = 23;
  localparam int edge_sel_lo = 22;
  localparam logic [31:0] setting_reset = 32'h0000_0000;
  // bits 21..0 are reserved or belong to the other port here
  localparam logic [31:0] setting_keep = 32'hffc0_0000;

  // ==========================================================
  // interrupt and state word layout
  // ==========================================================
  localparam int irq_w = 1; // one event: field identity edge
  localparam int irq_field_bit = 0;
  localparam logic [irq_w-1:0] irq_reset = 1'h0;
  localparam int state_w = 6; // live readback bits

  // ==========================================================
  // timing reference code on the video data stream
  // ==========================================================
  localparam logic [7:0] preamble_ones = 8'hff;
  localparam logic [7:0] preamble_zeros = 8'h00;
  localparam int code_field_bit = 6;
  localparam int code_vblank_bit = 5;
  localparam int code_hblank_bit = 4;

  // ==========================================================
  // mode encodings
  // ==========================================================
  typedef enum logic [1:0] {
    sync_pins_in, sync_hps_out, sync_field_mem, sync_brs_out
  } sync_cfg_t;
  typedef enum logic [2:0] {
    der_rise_direct, der_fall_direct, der_rise_forced,
    der_fall_forced, der_rise_free, der_fall_free,
    der_frame_sync, der_stream_codes
  } deriv_t;
  typedef enum logic [1:0] {
    edge_none, edge_rise, edge_fall, edge_both
  } edge_sel_t;
endpackage

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for a bundle of asynchronous pin levels
// assumes each bit is an independent level; no word coherence
`timescale 1ns/10ps
module pin_sync #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] meta; // first stage, read only by q

  // ==========================================================
  // two flops in series
  // ==========================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pin_sync

// *** rtl/timing_code_decoder.sv ***
// recovers blanking and field levels from embedded timing codes
// assumes sample pulses once per byte, data already synchronised
`timescale 1ns/10ps
module timing_code_decoder
  import video_port_a_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample,
  input wire logic [7:0] data,
  output logic h_level,
  output logic v_level,
  output logic f_level
);
  logic [1:0] seen; // preamble bytes matched so far

  // ==========================================================
  // preamble tracker: ones, zeros, zeros, then the code word
  // ==========================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen <= 2'h0;
    end else if (sample) begin
      if (data == preamble_ones) begin
        seen <= 2'h1; // a fresh preamble may restart anytime
      end else if (seen != 2'h0 && seen != 2'h3 &&
                   data == preamble_zeros) begin
        seen <= seen + 2'h1;
      end else begin
        seen <= 2'h0; // code word consumed or broken preamble
      end
    end
  end

  // ==========================================================
  // code word capture
  // ==========================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      h_level <= 1'b0;
      v_level <= 1'b0;
      f_level <= 1'b0;
    end else if (sample && seen == 2'h3) begin
      h_level <= data[code_hblank_bit];
      v_level <= data[code_vblank_bit];
      f_level <= data[code_field_bit];
    end
  end
endmodule // timing_code_decoder

// *** verif/video_port_a_sync_checker.sv ***
// checker for the port a sync block
// assumes one clk domain
`timescale 1ns/10ps
module video_port_a_sync_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic line_clock_port_a_out,
  input wire logic line_clock_port_a_oe,
  input wire logic hsync_pin_a_oe,
  input wire logic vsync_pin_a_oe,
  input wire logic internal_hstrobe_a,
  input wire logic internal_vstrobe_a,
  input wire logic irq
);
  // ==========================================================
  // all checks share the one clock and its reset
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ready_wait; $rose(penable) |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("pready late");
  property p_ready_pulse; pready |-> $past(psel && penable) ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stray");
  property p_reserved; pready && !pwrite |-> prdata[21:16] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved nonzero");
  property p_lclk; !line_clock_port_a_oe |-> !line_clock_port_a_out;
  endproperty
  a_lclk: assert property (p_lclk)
    else $error("line clock driven while input");
  // vsync never driven alone
  property p_pins; vsync_pin_a_oe |-> hsync_pin_a_oe; endproperty
  a_pins: assert property (p_pins)
    else $error("vsync driven alone");
  property p_hpulse; internal_hstrobe_a |=> !internal_hstrobe_a;
  endproperty
  a_hpulse: assert property (p_hpulse)
    else $error("hstrobe too long");
  property p_vpulse; internal_vstrobe_a |=> !internal_vstrobe_a;
  endproperty
  a_vpulse: assert property (p_vpulse)
    else $error("vstrobe too long");
  // irq drops only after a write
  property p_irq_fall; $fell(irq) |-> $past(pwrite, 2) || $past(pwrite, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without a write");
endmodule // video_port_a_sync_checker
bind video_port_a_sync video_port_a_sync_checker i_chk (.*);

// *** verif/video_source_model.sv ***
// video source on port a sync pins and port b clock
// assumes the bench resolves pins against enables
`timescale 1ns/10ps
module video_source_model (
  output logic line_clock,
  output logic hsync,
  output logic vsync
);
  // ==========================================================
  // line clock only runs inside a frame
  // ==========================================================
  logic run = 1'b0; // high while a frame is sent
  initial begin
    line_clock = 1'b0;
    hsync = 1'b0;
    vsync = 1'b0;
  end
  // 125 ns period, off the 4 ns grid so phases drift
  always #62.5 if (run) line_clock = ~line_clock;
  // one field; hsync levels at vsync rise and fall
  task automatic frame(input logic h_rise, input logic h_fall);
    run = 1'b1;
    @(posedge line_clock) hsync = h_rise;
    @(posedge line_clock) vsync = 1'b1;
    @(posedge line_clock) hsync = ~h_rise;
    @(posedge line_clock) hsync = h_fall;
    @(posedge line_clock) vsync = 1'b0;
    @(posedge line_clock) hsync = 1'b0;
    // stop on the low phase so the clock idles low between frames
    @(negedge line_clock) run = 1'b0;
  endtask
endmodule // video_source_model

// *** verif/video_port_a_sync_tb.sv ***
// bench: registers, pins, line clock, field irq
// assumes model and checker compiled too
`timescale 1ns/10ps
module video_port_a_sync_tb;
  import video_port_a_pkg::*;
  // ==========================================================
  // signals, wiring and instances
  // ==========================================================
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, video_port_a;
  logic [31:0] pwdata, prdata, rd;
  logic line_clock_port_a_in, line_clock_port_a_out, line_clock_port_a_oe;
  logic line_clock_port_b_in, hsync_pin_a_in, hsync_pin_a_out;
  logic hsync_pin_a_oe, vsync_pin_a_in, vsync_pin_a_out, vsync_pin_a_oe;
  logic hps_horizontal_gate, hps_vertical_gate, brs_horizontal_gate;
  logic brs_vertical_gate, field_memory_reset, hscaler_source_select_msb;
  logic brs_vsync, internal_hstrobe_a, internal_vstrobe_a;
  logic internal_field_flag_a, irq, src_hs, src_vs;
  int fails = 0, total_checks = 0, vcount = 0;
  // driven pins read back, else the source; an undriven line clock a pin reads low
  assign hsync_pin_a_in = hsync_pin_a_oe ? hsync_pin_a_out : src_hs;
  assign vsync_pin_a_in = vsync_pin_a_oe ? vsync_pin_a_out : src_vs;
  assign line_clock_port_a_in = line_clock_port_a_oe & line_clock_port_a_out;
  video_port_a_sync i_video_port_a_sync (.*);
  video_source_model i_video_source_model (.line_clock(line_clock_port_b_in),
    .hsync(src_hs), .vsync(src_vs));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // vstrobe counter for frame checks
  always @(posedge clk) if (internal_vstrobe_a === 1'b1) vcount++;
  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_regs();
    apb(1'b0, setting_addr, 32'h0);
    chk("setting reset", rd, setting_reset);
    apb(1'b1, setting_addr, 32'hffff_ffff);
    apb(1'b0, setting_addr, 32'h0);
    chk("reserved read", rd, setting_keep);
    apb(1'b0, 8'h60, 32'h0);
    chk("unmapped err", er, 1'b1);
    $display("test regs done");
  endtask
  // all sync configs, both polarities
  task automatic t_pins();
    logic [2:0] k;
    for (int c = 0; c < 4; c++) for (int p = 0; p < 2; p++) begin
      k = 3'(c * 3 + p);
      hps_horizontal_gate <= k[0];
      hps_vertical_gate <= k[1];
      brs_horizontal_gate <= k[1];
      brs_vertical_gate <= k[0];
      field_memory_reset <= k[2];
      apb(1'b1, setting_addr, {1'b0, 2'(c), 1'(p), 1'(p), 27'h0});
      repeat (2) @(posedge clk);
      chk("hs oe", hsync_pin_a_oe, c != 0);
      chk("vs oe", vsync_pin_a_oe, c == 1 || c == 3);
      if (c == 1) chk("hs hps", hsync_pin_a_out, k[0] ^ p[0]);
      if (c == 1) chk("vs hps", vsync_pin_a_out, k[1] ^ p[0]);
      if (c == 3) chk("hs brs", hsync_pin_a_out, k[1] ^ p[0]);
      if (c == 3) chk("vs brs", vsync_pin_a_out, k[0] ^ p[0]);
      if (c == 2 && p == 0) chk("hs fmr", hsync_pin_a_out, k[2]);
    end
    $display("test pins done");
  endtask
  task automatic t_lclk();
    int n;
    n = 0;
    apb(1'b1, setting_addr, 32'h8000_0000);
    fork i_video_source_model.frame(1'b0, 1'b0); join_none
    repeat (150) begin
      @(posedge clk);
      n += line_clock_port_a_out;
    end
    chk("lclk oe", line_clock_port_a_oe, 1'b1);
    chk("lclk copy", n > 0 && n < 150, 1'b1);
    repeat (120) @(posedge clk);
    apb(1'b1, setting_addr, 32'h0);
    $display("test line clock done");
  endtask
  // field from pins, irq set and clear
  task automatic t_field();
    int v0;
    apb(1'b1, irq_mask_addr, 32'h1);
    apb(1'b1, setting_addr, 32'h0040_0000);
    v0 = vcount;
    i_video_source_model.frame(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chk("vstrobes", vcount - v0, 1);
    chk("field 000", internal_field_flag_a, 1'b1);
    chk("irq set", irq, 1'b1);
    apb(1'b0, irq_status_addr, 32'h0);
    chk("status", rd, 32'h1);
    apb(1'b1, irq_status_addr, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq clear", irq, 1'b0);
    apb(1'b1, setting_addr, 32'h0140_0000);
    i_video_source_model.frame(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chk("field 001", internal_field_flag_a, 1'b0);
    chk("no fall irq", irq, 1'b0);
    $display("test field done");
  endtask
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {video_port_a, hscaler_source_select_msb} = '0;
    {hps_horizontal_gate, hps_vertical_gate, brs_horizontal_gate} = '0;
    {brs_vertical_gate, field_memory_reset} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_pins();
    t_lclk();
    t_field();
    tally_and_finish();
  end
endmodule // video_port_a_sync_tb
